// File: src/hpsis_top.sv
// Hot-plug serial input scanner: scan, filter, de-bounce, status and outputs
`timescale 1ns/100ps
module hpsis_top import hpsis_pkg::*; #(
  parameter int FILTER_CYCLES   = FILTER_CYC,
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  // Clock and chip reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Slot count strap
  input  wire logic [2:0]  slot_count_select_in,
  // Register port
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // Serial input link
  output logic             serial_in_load_n_out,
  output logic             serial_in_shift_clock_out,
  input  wire logic        serial_in_data_in,
  // Serial output link
  output logic             serial_out_data_out,
  output logic             serial_out_clock_out,
  output logic             serial_out_latch_out,
  // Interrupt request
  output logic             hp_interrupt_out
);
  localparam int SAMP_CYC = FILTER_CYCLES / SW_SAMPLES;
  localparam int TW       = $clog2(FILTER_CYCLES + 1);
  localparam int DW       = $clog2(DEBOUNCE_CYCLES + 1);

  if (SAMP_CYC < 1 || DEBOUNCE_CYCLES < 1) begin : g_chk
    $error("hpsis_top: filter or de-bounce count too small");
  end

  typedef enum logic [1:0] {SC_IDLE, SC_LOAD, SC_SHIFT} hpsis_scan_e;

  logic [2:0]  strap_s;
  logic        sid_s;
  logic [2:0]  rel_cnt;
  logic [2:0]  slots_sel;
  hpsis_mode_e mode;
  logic [2:0]  nslots;
  logic        stut;

  hpsis_scan_e st;
  logic [2:0]  ph;
  logic [2:0]  bitn;
  logic [3:0]  byten;
  logic [3:0]  last_byte;
  logic [7:0]  sr;
  logic        last_bit;
  logic        real_bit;
  logic        cur_bit;
  logic        byte_done;
  logic        new_scan;

  logic [31:0] raw;
  logic [31:0] nonint;
  logic [31:0] chg;
  logic [31:0] mask;
  logic [31:0] frozen;
  logic [31:8] post_v;
  logic [31:8] post_d;
  logic        int_pend;
  logic        scan_done;
  logic        in_busy;
  logic [3:0]  ptr;
  logic        ptr_go;
  logic [7:0]  data_port;
  logic        long_cfg;
  logic [7:0]  slot_en;
  logic [7:0]  slot_pwr;
  logic [7:0]  gpo;

  logic          flt_on;
  logic [7:0]    cand;
  logic [5:0]    samp_cnt;
  logic [TW-1:0] tmr;
  logic          samp_tick;
  logic          sw_commit;
  logic          db_on;
  logic [DW-1:0] db_cnt;
  logic [31:8]   ns_diff;
  logic          ns_commit;
  logic [31:0]   upd;
  logic [31:0]   ack;
  logic [31:0]   apply;
  logic [31:0]   upd_all;
  logic [31:0]   fire;

  logic                wr_chg;
  logic                wr_misc;
  logic                ob_busy;
  logic                ob_go;
  logic [OUT_BITS-1:0] frame;
  logic [5:0]          out_len;
  logic [31:0]         misc_val;
  logic [31:0]         next_rdata;

  hpsis_sync3 #(.W(4)) u_sync (
    .clk_in (ref_clk_in),
    .rst_in (rst_in),
    .d_in   ({slot_count_select_in, serial_in_data_in}),
    .q_out  ({strap_s, sid_s})
  );

  // Strap caught once the synchroniser has settled after release
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rel_cnt   <= 3'h0;
      slots_sel <= 3'h0;
    end else if (rel_cnt != 3'h5) begin
      rel_cnt <= rel_cnt + 3'h1;
      if (rel_cnt == 3'h4) begin
        slots_sel <= strap_s;
      end
    end
  end

  assign mode   = hpsis_decode(slots_sel);
  assign nslots = hpsis_slots(slots_sel);
  assign stut   = (mode == HPSIS_SER);

  assign wr_chg  = reg_wr_in && (reg_addr_in == OFS_CHG);
  assign wr_misc = reg_wr_in && (reg_addr_in == OFS_MISC);

  // Scan sequencer; one bit slot is eight core clocks
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ph    <= 3'h0;
      st    <= SC_IDLE;
      bitn  <= 3'h0;
      byten <= 4'h0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        unique case (st)
          SC_IDLE: begin
            if (mode != HPSIS_OFF) begin
              st <= SC_LOAD;
            end
          end
          SC_LOAD: begin
            st    <= SC_SHIFT;
            bitn  <= 3'h0;
            byten <= 4'h0;
          end
          SC_SHIFT: begin
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) begin
              // Byte 15 always ends a scan, even if the stretch drops away
              if (byten == last_byte || byten == 4'hF) begin
                st <= (mode == HPSIS_OFF) ? SC_IDLE : SC_LOAD;
              end else begin
                byten <= byten + 4'h1;
              end
            end
          end
          default: st <= SC_IDLE;
        endcase
      end
    end
  end

  // Pointer past byte 7 stretches the current scan to reach it
  assign last_byte = (long_cfg || (in_busy && ptr[3])) ? 4'hF : 4'h7;
  assign real_bit  = byten[3] || !stut || (bitn < nslots);
  assign cur_bit   = real_bit ? sid_s : last_bit;
  assign byte_done = (st == SC_SHIFT) && (ph == 3'h7) && (bitn == 3'h7);

  // Capture just before the rising edge that presents the next bit
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sr       <= RST_BYTE;
      last_bit <= 1'b0;
    end else if (st == SC_SHIFT && ph == 3'h3) begin
      sr       <= {cur_bit, sr[7:1]};
      last_bit <= cur_bit;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      serial_in_load_n_out      <= 1'b1;
      serial_in_shift_clock_out <= 1'b0;
    end else begin
      serial_in_load_n_out      <= (st != SC_LOAD);
      serial_in_shift_clock_out <= (st == SC_SHIFT) && real_bit
                                   && (ph >= 3'h3) && (ph <= 3'h6);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      raw      <= RST_WORD;
      nonint   <= RST_WORD;
      new_scan <= 1'b0;
    end else begin
      new_scan <= byte_done && (byten == 4'(INT_BYTES - 1));
      if (byte_done && byten < 4'(INT_BYTES)) begin
        raw[byten[1:0]*8 +: 8] <= sr;
      end else if (byte_done && byten < 4'(SCAN_BYTES)) begin
        nonint[byten[1:0]*8 +: 8] <= sr;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scan_done <= 1'b0;
    end else begin
      scan_done <= (scan_done && !(wr_misc && reg_wdata_in[MISC_SDONE]))
                   || (byte_done && byten == 4'(SCAN_BYTES - 1));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      in_busy   <= 1'b0;
      ptr_go    <= 1'b0;
      ptr       <= 4'h0;
      data_port <= RST_BYTE;
    end else if (reg_wr_in && reg_addr_in == OFS_PTR) begin
      in_busy <= 1'b1;
      ptr_go  <= 1'b0;
      ptr     <= reg_wdata_in[3:0];
    end else if (in_busy && ptr_go && byte_done && byten == ptr) begin
      data_port <= sr;
      in_busy   <= 1'b0;
    end else if (st == SC_LOAD) begin
      // Only a scan begun after the pointer write may fill the port
      ptr_go <= 1'b1;
    end
  end

  // Switch glitch filter over byte 0
  assign samp_tick = flt_on && (tmr == TW'(SAMP_CYC - 1));
  assign sw_commit = samp_tick && (raw[7:0] == cand)
                     && (samp_cnt == 6'(SW_SAMPLES - 1));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      flt_on   <= 1'b0;
      cand     <= RST_BYTE;
      samp_cnt <= 6'h00;
      tmr      <= '0;
    end else if (!flt_on) begin
      if (new_scan && |((raw[7:0] ^ chg[7:0]) & ~frozen[7:0])) begin
        flt_on   <= 1'b1;
        cand     <= raw[7:0];
        samp_cnt <= 6'h00;
        tmr      <= '0;
      end
    end else if (samp_tick) begin
      tmr <= '0;
      if (raw[7:0] != cand) begin
        cand     <= raw[7:0];
        samp_cnt <= 6'h00;
      end else if (samp_cnt == 6'(SW_SAMPLES - 1)) begin
        flt_on <= 1'b0;
      end else begin
        samp_cnt <= samp_cnt + 6'h01;
      end
    end else begin
      tmr <= tmr + TW'(1);
    end
  end

  // Non-switch de-bounce window
  assign ns_diff   = (raw[31:8] ^ chg[31:8]) & ~frozen[31:8];
  assign ns_commit = new_scan && !db_on && |ns_diff;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      db_on  <= 1'b0;
      db_cnt <= '0;
    end else if (ns_commit) begin
      db_on  <= 1'b1;
      db_cnt <= '0;
    end else if (db_on) begin
      if (db_cnt == DW'(DEBOUNCE_CYCLES - 1)) begin
        db_on <= 1'b0;
      end else begin
        db_cnt <= db_cnt + DW'(1);
      end
    end
  end

  // Every update flips only bits that differ, so XOR applies it
  always_comb begin
    upd = RST_WORD;
    if (sw_commit) begin
      upd[7:0] = (cand ^ chg[7:0]) & ~frozen[7:0];
    end
    if (ns_commit) begin
      upd[31:8] = ns_diff;
    end
    ack     = wr_chg ? (reg_wdata_in & frozen) : RST_WORD;
    apply   = ack & {post_v, 8'h00};
    upd_all = upd | (apply & ({post_d, 8'h00} ^ chg));
    fire    = upd_all & ~mask;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      chg    <= RST_WORD;
      frozen <= RST_WORD;
    end else begin
      chg    <= chg ^ upd_all;
      frozen <= (frozen & ~ack) | fire;
    end
  end

  // A frozen non-switch bit (bits 8 to 31) past de-bounce holds at most one further change
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      post_v <= '0;
      post_d <= '0;
    end else begin
      for (int i = 8; i < 32; i++) begin
        if (apply[i]) begin
          post_v[i] <= 1'b0;
        end else if (new_scan && !db_on && frozen[i] && !post_v[i]
                     && (raw[i] != chg[i])) begin
          post_v[i] <= 1'b1;
          post_d[i] <= raw[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      int_pend         <= 1'b0;
      hp_interrupt_out <= 1'b0;
    end else begin
      // An event in the clearing cycle wins, so it is never lost
      int_pend <= (int_pend && !(wr_misc && reg_wdata_in[MISC_INTP]))
                  || |fire;
      hp_interrupt_out <= int_pend;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mask     <= RST_MASK;
      long_cfg <= 1'b0;
      slot_en  <= RST_BYTE;
      slot_pwr <= RST_BYTE;
      gpo      <= RST_BYTE;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_MASK:     mask     <= reg_wdata_in;
        OFS_SICFG:    long_cfg <= reg_wdata_in[SICFG_LONG];
        OFS_SLOT_EN:  slot_en  <= reg_wdata_in[7:0];
        OFS_SLOT_PWR: slot_pwr <= reg_wdata_in[7:0];
        OFS_GPO:      gpo      <= reg_wdata_in[7:0];
        default: ;
      endcase
    end
  end

  // Seven control bits per slot, general outputs last
  always_comb begin
    frame = '0;
    for (int i = 0; i < MAX_SLOTS; i++) begin
      frame[i*SLOT_OBITS +: SLOT_OBITS] = {slot_en[i], !slot_en[i],
        slot_en[i], !slot_en[i], !slot_en[i], slot_pwr[i], 1'b0};
    end
    frame[MAX_SLOTS*SLOT_OBITS +: GPO_BITS] = gpo;
  end

  assign out_len = stut ? 6'(nslots * SLOT_OBITS + GPO_BITS)
                        : 6'(2 * SLOT_OBITS);
  assign ob_go   = wr_misc && reg_wdata_in[MISC_OGO] && (mode != HPSIS_OFF);

  hpsis_oshift #(.NBITS(OUT_BITS)) u_oshift (
    .clk_in    (ref_clk_in),
    .rst_in    (rst_in),
    .go_in     (ob_go),
    .frame_in  (frame),
    .len_in    (out_len),
    .busy_out  (ob_busy),
    .data_out  (serial_out_data_out),
    .clk_out   (serial_out_clock_out),
    .latch_out (serial_out_latch_out)
  );

  always_comb begin
    misc_val                           = RST_WORD;
    misc_val[MISC_INTP]                = int_pend;
    misc_val[MISC_IBUSY]               = in_busy;
    misc_val[MISC_OGO]                 = ob_busy;
    misc_val[MISC_STRAP +: 3]          = slots_sel;
    misc_val[MISC_SDONE]               = scan_done;
    unique case (reg_addr_in)
      OFS_CHG:      next_rdata = chg;
      OFS_MASK:     next_rdata = mask;
      OFS_MISC:     next_rdata = misc_val;
      OFS_NONINT:   next_rdata = nonint;
      OFS_PTR:      next_rdata = {28'h0000000, ptr};
      OFS_DATA:     next_rdata = {24'h000000, data_port};
      OFS_SICFG:    next_rdata = {31'h00000000, long_cfg};
      OFS_SLOT_EN:  next_rdata = {24'h000000, slot_en};
      OFS_SLOT_PWR: next_rdata = {24'h000000, slot_pwr};
      OFS_GPO:      next_rdata = {24'h000000, gpo};
      default:      next_rdata = RST_WORD;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= RST_WORD;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end
endmodule

// File: src/hpsis_pkg.sv
// Constants, types and decode helpers for the hot-plug serial input scanner
package hpsis_pkg;

  localparam int CLK_MHZ      = 200;
  localparam int FILTER_MS    = 15;
  localparam int DEBOUNCE_MS  = 8;
  localparam int FILTER_CYC   = FILTER_MS * 1000 * CLK_MHZ;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int SW_SAMPLES   = 32;
  localparam int SHIFT_DIV    = 8;
  localparam int SCAN_BYTES   = 8;
  localparam int LONG_BYTES   = 16;
  localparam int INT_BYTES    = 4;
  localparam int MAX_SLOTS    = 6;
  localparam int SLOT_OBITS   = 7;
  localparam int GPO_BITS     = 8;
  localparam int OUT_BITS     = MAX_SLOTS * SLOT_OBITS + GPO_BITS;

  localparam logic [7:0] OFS_SLOT_EN  = 8'h01;
  localparam logic [7:0] OFS_GPO      = 8'h13;
  localparam logic [7:0] OFS_SLOT_PWR = 8'h2D;
  localparam logic [7:0] OFS_CHG      = 8'h40;
  localparam logic [7:0] OFS_MASK     = 8'h44;
  localparam logic [7:0] OFS_MISC     = 8'h48;
  localparam logic [7:0] OFS_NONINT   = 8'h4C;
  localparam logic [7:0] OFS_PTR      = 8'h50;
  localparam logic [7:0] OFS_DATA     = 8'h54;
  localparam logic [7:0] OFS_SICFG    = 8'h58;

  localparam int MISC_INTP  = 0;
  localparam int MISC_IBUSY = 1;
  localparam int MISC_OGO   = 2;
  localparam int MISC_STRAP = 8;
  localparam int MISC_SDONE = 12;
  localparam int SICFG_LONG = 0;

  localparam logic [31:0] RST_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  typedef enum logic [1:0] {HPSIS_OFF, HPSIS_PAR, HPSIS_SER} hpsis_mode_e;

  function automatic hpsis_mode_e hpsis_decode(input logic [2:0] sel);
    unique case (sel)
      3'h1, 3'h2:             return HPSIS_PAR;
      3'h3, 3'h4, 3'h5, 3'h6: return HPSIS_SER;
      default:                return HPSIS_OFF;
    endcase
  endfunction

  // Slots served; parallel modes shift all bits
  function automatic logic [2:0] hpsis_slots(input logic [2:0] sel);
    if (hpsis_decode(sel) == HPSIS_SER) begin
      return sel;
    end
    return 3'h6;
  endfunction

endpackage

// File: src/hpsis_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module hpsis_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      q_out <= '0;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q_out[i] <= s3[i];
        end
      end
    end
  end
endmodule

// File: src/hpsis_oshift.sv
// Demand-driven serial output shifter for slot controls
`timescale 1ns/100ps
module hpsis_oshift import hpsis_pkg::*; #(
  parameter int NBITS = OUT_BITS
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Request
  input  wire logic             go_in,
  input  wire logic [NBITS-1:0] frame_in,
  input  wire logic [5:0]       len_in,
  output logic                  busy_out,
  // Serial output pins
  output logic                  data_out,
  output logic                  clk_out,
  output logic                  latch_out
);
  typedef enum logic [1:0] {OS_IDLE, OS_BITS, OS_LATCH} hpsis_os_e;

  hpsis_os_e        st;
  logic [2:0]       ph;
  logic [5:0]       left;
  logic [NBITS-1:0] sh;

  if (NBITS > 63) begin : g_chk
    $error("hpsis_oshift: NBITS too large for length counter");
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st        <= OS_IDLE;
      ph        <= 3'h0;
      left      <= 6'h00;
      sh        <= '0;
      busy_out  <= 1'b0;
      data_out  <= 1'b0;
      clk_out   <= 1'b0;
      latch_out <= 1'b0;
    end else begin
      ph <= ph + 3'h1;
      unique case (st)
        OS_IDLE: begin
          ph      <= 3'h0;
          clk_out <= 1'b0;
          if (go_in && len_in != 6'h00) begin
            st       <= OS_BITS;
            sh       <= frame_in;
            left     <= len_in;
            busy_out <= 1'b1;
          end
        end
        OS_BITS: begin
          data_out <= sh[0];
          clk_out  <= (ph >= 3'h3) && (ph <= 3'h6);
          if (ph == 3'h7) begin
            sh   <= sh >> 1;
            left <= left - 6'h01;
            if (left == 6'h01) begin
              st <= OS_LATCH;
            end
          end
        end
        OS_LATCH: begin
          latch_out <= (ph != 3'h7);
          if (ph == 3'h7) begin
            st       <= OS_IDLE;
            busy_out <= 1'b0;
          end
        end
        default: st <= OS_IDLE;
      endcase
    end
  end
endmodule

// File: sim/hpsis_props.sv
// Port checker for the hot-plug serial input scanner
`timescale 1ns/100ps
module hpsis_props import hpsis_pkg::*; (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  // Strap and register port
  input wire logic [2:0]  slot_count_select_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  // Serial links and interrupt
  input wire logic        serial_in_load_n_out,
  input wire logic        serial_in_shift_clock_out,
  input wire logic        serial_out_clock_out,
  input wire logic        serial_out_latch_out,
  input wire logic        hp_interrupt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic [15:0] gap;
  logic [7:0]  rises;
  logic        armed;
  logic        pend_clr;
  logic [3:0]  nsl;

  assign pend_clr = reg_wr_in && reg_addr_in == OFS_MISC && reg_wdata_in[MISC_INTP];
  // Parallel straps shift every bit, like bytes without stutter
  assign nsl = (slot_count_select_in inside {[3'h3:3'h6]}) ? {1'b0, slot_count_select_in} : 4'h8;

  // Armed only after a first load, so a scan cut by reset is never measured
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gap   <= 16'h0000;
      rises <= 8'h00;
      armed <= 1'b0;
    end else if (!serial_in_load_n_out) begin
      gap   <= 16'h0000;
      rises <= 8'h00;
      armed <= 1'b1;
    end else begin
      gap   <= gap + 16'h0001;
      rises <= rises + {7'h00, $rose(serial_in_shift_clock_out)};
    end
  end

  property p_load_len;
    $fell(serial_in_load_n_out) |-> !serial_in_load_n_out [*8] ##1 serial_in_load_n_out;
  endproperty
  a_load_len: assert property (p_load_len) else $error("load strobe width wrong");

  property p_sclk_high;
    $rose(serial_in_shift_clock_out) |-> serial_in_shift_clock_out [*4] ##1 !serial_in_shift_clock_out;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("shift clock high time wrong");

  property p_sclk_low;
    $fell(serial_in_shift_clock_out) |-> !serial_in_shift_clock_out [*3];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("shift clock low time short");

  property p_sclk_in_load;
    !serial_in_load_n_out |-> !serial_in_shift_clock_out;
  endproperty
  a_sclk_in_load: assert property (p_sclk_in_load) else $error("shift clock during load");

  property p_scan_len;
    $fell(serial_in_load_n_out) && armed |-> gap == 16'h0200 || gap == 16'h0400;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan length wrong");

  property p_scan_cont;
    armed && serial_in_load_n_out |-> gap <= 16'h0400;
  endproperty
  a_scan_cont: assert property (p_scan_cont) else $error("scan stopped");

  property p_stutter;
    $fell(serial_in_load_n_out) && armed |->
      rises == {1'b0, nsl, 3'h0} || rises == {1'b0, nsl, 3'h0} + 8'h40;
  endproperty
  a_stutter: assert property (p_stutter) else $error("shift clock count wrong");

  property p_int_hold;
    hp_interrupt_out && !pend_clr && !$past(pend_clr) |=> hp_interrupt_out;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped");

  property p_out_clk;
    $rose(serial_out_clock_out) |-> serial_out_clock_out [*4] ##1 !serial_out_clock_out;
  endproperty
  a_out_clk: assert property (p_out_clk) else $error("output clock width wrong");

  property p_latch;
    $rose(serial_out_latch_out) |-> serial_out_latch_out [*7] ##1 !serial_out_latch_out;
  endproperty
  a_latch: assert property (p_latch) else $error("output latch width wrong");

  c_irq: cover property ($rose(hp_interrupt_out));
  c_latch: cover property ($rose(serial_out_latch_out));
  c_long: cover property ($fell(serial_in_load_n_out) && gap == 16'h0400);
endmodule

bind hpsis_top hpsis_props i_hpsis_props (.ref_clk_in, .rst_in, .slot_count_select_in,
  .reg_wr_in, .reg_addr_in, .reg_wdata_in, .serial_in_load_n_out,
  .serial_in_shift_clock_out, .serial_out_clock_out, .serial_out_latch_out,
  .hp_interrupt_out);

// File: sim/hpsis_sr_model.sv
// External parallel-in shift register chain feeding the scanner
`timescale 1ns/100ps
module hpsis_sr_model (
  // Slot inputs and strap
  input  wire logic [127:0] image_in,
  input  wire logic [2:0]   slot_count_select_in,
  // Serial link
  input  wire logic         load_n_in,
  input  wire logic         shift_clock_in,
  output logic              data_out
);
  logic [127:0] chain = 128'h0;
  int           len = 1;
  int           ptr = 0;
  int           n;

  // Unused stuttered positions have no flop, so the chain is packed
  always @(negedge load_n_in) begin
    len = 0;
    for (int k = 0; k < 16; k++) begin
      n = (k < 8 && slot_count_select_in inside {[3'h3:3'h6]}) ? slot_count_select_in : 8;
      for (int b = 0; b < n; b++) begin
        chain[len] = image_in[8*k+b];
        len++;
      end
    end
    ptr = 0;
  end

  always @(posedge shift_clock_in) begin
    ptr++;
  end

  // Past the chain end the line carries nothing valid
  assign data_out = (ptr < len) ? chain[ptr] : ~chain[len-1];
endmodule

// File: sim/tb_hpsis_top.sv
// Self-checking bench for the hot-plug serial input scanner
`timescale 1ns/100ps
module tb_hpsis_top import hpsis_pkg::*;;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [2:0]   strap = 3'h6;
  logic         wr = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic [127:0] image = 128'h5A81_8181_8181_9C81_1E33_0C27_013F_2A15;
  logic [31:0]  rdata;
  logic         ld_n;
  logic         sclk;
  logic         sdata;
  logic         so_clk;
  logic         so_d;
  logic [63:0]  ob = 64'h0;
  logic         irq;
  logic [7:0]   regs [3] = '{OFS_SLOT_EN, OFS_GPO, OFS_SLOT_PWR};
  logic [2:0]   straps [5] = '{3'h0, 3'h7, 3'h5, 3'h3, 3'h1};
  int           ptrs [3] = '{2, 9, 15};
  int           n_fail = 0;
  int           num_checks = 0;
  int           lc = 0;
  int           oc = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (!ld_n) lc++;
  always @(posedge so_clk) begin
    oc++;
    ob = {so_d, ob[63:1]};
  end

  hpsis_top #(.FILTER_CYCLES(640), .DEBOUNCE_CYCLES(200)) i_hpsis_top (
    .ref_clk_in(clk), .rst_in(rst), .slot_count_select_in(strap), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .serial_in_load_n_out(ld_n), .serial_in_shift_clock_out(sclk),
    .serial_in_data_in(sdata), .serial_out_data_out(so_d), .serial_out_clock_out(so_clk),
    .serial_out_latch_out(), .hp_interrupt_out(irq));

  hpsis_sr_model i_hpsis_sr_model (.image_in(image), .slot_count_select_in(strap),
    .load_n_in(ld_n), .shift_clock_in(sclk), .data_out(sdata));

  // Byte as seen after stutter: positions from n up repeat bit n-1
  function automatic logic [7:0] st(input logic [7:0] b, input int n);
    for (int i = n; i < 8; i++) b[i] = b[n-1];
    return b;
  endfunction

  function automatic logic [7:0] ib(input int k);
    return image[8*k +: 8];
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1 chk(rdata & m, e);
  endtask

  task automatic wait_clr(input logic [7:0] a, input logic [31:0] m);
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1 addr = a;
      @(posedge clk);
      #1 if ((rdata & m) === 32'h0) return;
    end
    n_fail++;
    give_verdict();
  endtask

  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1 if (irq === 1'b1) return;
    end
    n_fail++;
    give_verdict();
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    #1 rst = 1'b1;
    strap = s;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    lc = 0;
  endtask

  initial begin
    do_reset(3'h6);
    rchk(OFS_MASK, 32'hFFFFFFFF, RST_MASK);
    foreach (regs[i]) begin
      wreg(regs[i], 32'hFFFFFFA5);
      rchk(regs[i], 32'hFFFFFFFF, 32'h000000A5);
    end
    rchk(8'h60, 32'hFFFFFFFF, 32'h0);
    rchk(OFS_MISC, 32'h700, 32'h600);
    // Several scans so every masked change has committed
    repeat (6000) @(posedge clk);
    rchk(OFS_CHG, 32'hFFFFFFFF, {st(ib(3), 6), st(ib(2), 6), st(ib(1), 6), st(ib(0), 6)});
    rchk(OFS_NONINT, 32'hFFFFFFFF, {st(ib(7), 6), st(ib(6), 6), st(ib(5), 6), st(ib(4), 6)});
    rchk(OFS_MISC, 32'h1001, 32'h1000);
    wreg(OFS_MASK, 32'hFFFFFEFF);
    image[8] = 1'b1;
    wait_irq(1500);
    rchk(OFS_MISC, 32'h1, 32'h1);
    rchk(OFS_CHG, 32'h100, 32'h100);
    image[8] = 1'b0;
    repeat (1200) @(posedge clk);
    rchk(OFS_CHG, 32'h100, 32'h100);
    wreg(OFS_MISC, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    wreg(OFS_CHG, 32'h100);
    rchk(OFS_CHG, 32'h100, 32'h0);
    wreg(OFS_MISC, 32'h1);
    rchk(OFS_MISC, 32'h1, 32'h0);
    wreg(OFS_MASK, 32'hFFFFFFFE);
    image[0] = 1'b0;
    // Bit 1 flips once per scan, so no 32 equal samples until it stops
    for (int i = 0; i < 2080; i++) begin
      if (i % 520 == 0) begin
        image[1] = ~image[1];
      end
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
    end
    wait_irq(2000);
    rchk(OFS_CHG, 32'h3, 32'h0);
    wreg(OFS_SICFG, 32'h1);
    foreach (ptrs[i]) begin
      wreg(OFS_PTR, ptrs[i]);
      rchk(OFS_MISC, 32'h2, 32'h2);
      wait_clr(OFS_MISC, 32'h2);
      rchk(OFS_DATA, 32'hFF, {24'h0, (ptrs[i] < 8) ? st(ib(ptrs[i]), 6) : ib(ptrs[i])});
    end
    oc = 0;
    wreg(OFS_MISC, 32'h4);
    rchk(OFS_MISC, 32'h4, 32'h4);
    wait_clr(OFS_MISC, 32'h4);
    chk(oc, 6 * SLOT_OBITS + GPO_BITS);
    chk(ob[63:56], 32'hA5);
    chk(ob[20:14], 32'h52);
    chk(ob[27:21], 32'h2C);
    foreach (straps[i]) begin
      do_reset(straps[i]);
      repeat (700) @(posedge clk);
      rchk(OFS_MISC, 32'h700, {21'h0, straps[i], 8'h0});
      chk(lc != 0, straps[i] inside {[3'h1:3'h6]});
    end
    give_verdict();
  end
endmodule
